//--- logic/hbcs_regs.sv
/*
 * Bridge command and status configuration registers of device 0,
 * with the system-error message path toward the I/O controller hub.
 * Assumes a dword configuration port: request held one cycle, answer
 * one cycle later. Abort and error events are one-cycle pulses.
 */
`timescale 1ns/1ps
module hbcs_regs
    import hbcs_pkg::*;
(
    // Clock, enable and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Configuration access
    input wire logic cfg_req_i,
    input wire logic cfg_we_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_ack_o,
    // Error and completion events
    input wire logic dev0_err_i,
    input wire logic dev1_err_i,
    input wire logic dev1_msg_en_i,
    input wire logic got_master_abort_i,
    input wire logic got_target_abort_i,
    input wire logic special_cycle_i,
    // Hub link message
    output logic msg_req_o,
    input wire logic msg_ack_i,
    output logic msg_mech_en_o
);
    logic error_message_enable_q;
    logic error_message_sent_flag;
    logic got_master_abort_flag;
    logic got_target_abort_flag;
    logic dev0_sent;
    logic hit;
    logic wr;
    logic [15:0] cmd_val;
    logic [15:0] sts_val;
    logic [31:0] rdata_d;

    function automatic logic w1c(input logic [31:0] data, input logic [3:0] be, input int bit_pos);
        w1c = data[bit_pos] && be[bit_pos / 8];
    endfunction

    assign hit = (cfg_addr_i[7:2] == HBCS_DWORD_INDEX);
    assign wr = cfg_req_i && cfg_we_i && hit && ce_i;
    // Special cycles touch no state at all
    // special_cycle_i is deliberately left unread

    // Only the enable bit is storage in the command register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            error_message_enable_q <= HBCS_CMD_RESET[HBCS_CMD_MSG_EN_BIT];
        end else if (wr && cfg_be_i[1]) begin
            error_message_enable_q <= cfg_wdata_i[HBCS_CMD_MSG_EN_BIT];
        end
    end

    // Fixed bits come from constants, not storage
    always_comb begin
        cmd_val = HBCS_CMD_FIXED;
        cmd_val[HBCS_CMD_MSG_EN_BIT] = error_message_enable_q;
    end

    // Status image: timing code and capability bits are constants
    always_comb begin
        sts_val = HBCS_STS_FIXED;
        sts_val[HBCS_STS_MSG_SENT_BIT] = error_message_sent_flag;
        sts_val[HBCS_STS_MABORT_BIT] = got_master_abort_flag;
        sts_val[HBCS_STS_TABORT_BIT] = got_target_abort_flag;
        sts_val[HBCS_STS_TIMING_LO_BIT +: 2] = HBCS_SELECT_TIMING_CODE;
    end

    // Bits 15 and 8 are write-clear but hardwired to zero, so no storage
    hbcs_flag u_sent_flag (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .set_i(dev0_sent),
        .clr_i(wr && w1c(cfg_wdata_i, cfg_be_i, HBCS_STS_SHIFT + HBCS_STS_MSG_SENT_BIT)),
        .flag_o(error_message_sent_flag)
    );

    hbcs_flag u_mabort_flag (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .set_i(got_master_abort_i),
        .clr_i(wr && w1c(cfg_wdata_i, cfg_be_i, HBCS_STS_SHIFT + HBCS_STS_MABORT_BIT)),
        .flag_o(got_master_abort_flag)
    );

    hbcs_flag u_tabort_flag (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .set_i(got_target_abort_i),
        .clr_i(wr && w1c(cfg_wdata_i, cfg_be_i, HBCS_STS_SHIFT + HBCS_STS_TABORT_BIT)),
        .flag_o(got_target_abort_flag)
    );

    // No error pin: the only report path is the link message
    hbcs_sender u_sender (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .dev0_err_i(dev0_err_i),
        .dev0_en_i(error_message_enable_q),
        .dev1_err_i(dev1_err_i),
        .dev1_en_i(dev1_msg_en_i),
        .msg_req_o(msg_req_o),
        .msg_ack_i(msg_ack_i),
        .dev0_sent_o(dev0_sent)
    );

    assign msg_mech_en_o = error_message_enable_q || dev1_msg_en_i;

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit) begin
            rdata_d = {sts_val, cmd_val};
        end else begin
            rdata_d = 32'h0000_0000;
        end
    end

    // Answer one cycle after the request, data registered
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_ack_o <= 1'b0;
            cfg_rdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            cfg_ack_o <= cfg_req_i;
            if (cfg_req_i && !cfg_we_i) begin
                cfg_rdata_o <= rdata_d;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    logic past_valid_q;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            past_valid_q <= 1'b0;
        end else begin
            past_valid_q <= 1'b1;
        end
    end

    cmd_fixed_bits_a: assert property ((cmd_val & 16'hfeff) == HBCS_CMD_FIXED)
        else $error("command fixed bits wrong");
    sts_fixed_bits_a: assert property ((sts_val & 16'h8f9f) == HBCS_STS_FIXED)
        else $error("status fixed bits wrong");
    read_image_a: assert property (cfg_req_i && !cfg_we_i && hit && ce_i |=> cfg_ack_o
        && cfg_rdata_o == {$past(sts_val), $past(cmd_val)})
        else $error("read data not the register image");
    enable_write_a: assert property (wr && cfg_be_i[1] |=> error_message_enable_q == $past(cfg_wdata_i[8]))
        else $error("enable bit not written");
    no_msg_disabled_a: assert property (!error_message_enable_q && !dev1_msg_en_i && !msg_req_o
        ##1 !error_message_enable_q && !dev1_msg_en_i |-> !msg_req_o)
        else $error("message offered while disabled");
    msg_on_error_a: assert property (ce_i && dev0_err_i && error_message_enable_q && !msg_req_o
        ##1 ce_i |=> msg_req_o)
        else $error("enabled error produced no message");
    sent_sets_flag_a: assert property (dev0_sent |=> error_message_sent_flag)
        else $error("sent flag not set");
    abort_sets_flag_a: assert property (ce_i && got_master_abort_i |=> got_master_abort_flag)
        else $error("master abort flag not set");
    tabort_flag_a: assert property (ce_i && got_target_abort_i |=> got_target_abort_flag)
        else $error("target abort flag not set");
    flag_holds_a: assert property (past_valid_q && got_master_abort_flag
        && !(wr && cfg_wdata_i[29] && cfg_be_i[3]) |=> got_master_abort_flag)
        else $error("flag dropped without write of one");
    flag_clears_a: assert property (wr && cfg_be_i[3] && cfg_wdata_i[28] && !got_target_abort_i
        |=> !got_target_abort_flag)
        else $error("target abort flag not cleared");
    mech_enable_a: assert property (msg_mech_en_o == (cmd_val[8] || dev1_msg_en_i))
        else $error("mechanism enable not ORed");
    special_quiet_a: assert property (special_cycle_i && !cfg_req_i && !dev0_sent
        && !got_master_abort_i && !got_target_abort_i |=> $stable(sts_val) && $stable(cmd_val))
        else $error("special cycle changed state");
    msg_held_a: assert property (msg_req_o && !(msg_ack_i && ce_i) |=> msg_req_o)
        else $error("message request dropped before ack");
    sts_reset_a: assert property (!past_valid_q |-> sts_val == HBCS_STS_RESET)
        else $error("status not at reset value");
    cmd_reset_a: assert property (!past_valid_q |-> cmd_val == HBCS_CMD_RESET)
        else $error("command not at reset value");
    tabort_holds_a: assert property (past_valid_q && got_target_abort_flag
        && !(wr && cfg_wdata_i[28] && cfg_be_i[3]) |=> got_target_abort_flag)
        else $error("target abort flag dropped without write of one");
    sent_holds_a: assert property (past_valid_q && error_message_sent_flag
        && !(wr && cfg_wdata_i[30] && cfg_be_i[3]) |=> error_message_sent_flag)
        else $error("sent flag dropped without write of one");

    msg_sent_c: cover property (dev0_sent);
    both_aborts_c: cover property (got_master_abort_flag && got_target_abort_flag);
    set_clear_same_c: cover property (wr && cfg_wdata_i[29] && got_master_abort_i);
    dev1_only_c: cover property (msg_req_o && !error_message_enable_q);
endmodule // hbcs_regs

//--- logic/hbcs_pkg.sv
/*
 * Constants for the bridge command/status register pair: offsets,
 * field positions, reset values and the message-sender states.
 * Assumes nothing of its surroundings; imported by hbcs_regs and hbcs_sender, not by hbcs_flag.
 */
package hbcs_pkg;
    // Configuration space offsets as printed
    localparam logic [7:0] HBCS_CMD_OFFSET = 8'h04;
    localparam logic [7:0] HBCS_STS_OFFSET = 8'h06;
    // Dword index holding both registers (command low, status high)
    localparam logic [5:0] HBCS_DWORD_INDEX = 6'h01;
    localparam int HBCS_STS_SHIFT = 16;

    // Reset values
    localparam logic [15:0] HBCS_CMD_RESET = 16'h0006;
    localparam logic [15:0] HBCS_STS_RESET = 16'h0090;
    // Hardwired ones of command: master_allow, memory_space_allow
    localparam logic [15:0] HBCS_CMD_FIXED = 16'h0006;
    // Hardwired ones of status: back_to_back_capable, capability_list_present
    localparam logic [15:0] HBCS_STS_FIXED = 16'h0090;

    // Command field positions
    localparam int HBCS_CMD_MSG_EN_BIT = 8;
    // Status field positions
    localparam int HBCS_STS_PARITY_ERR_BIT = 15;
    localparam int HBCS_STS_MSG_SENT_BIT = 14;
    localparam int HBCS_STS_MABORT_BIT = 13;
    localparam int HBCS_STS_TABORT_BIT = 12;
    localparam int HBCS_STS_TIMING_LO_BIT = 9;
    localparam logic [1:0] HBCS_SELECT_TIMING_CODE = 2'h0;

    // Message sender states
    typedef enum logic [0:0] {
        HBCS_SND_IDLE = 1'b0,
        HBCS_SND_BUSY = 1'b1
    } hbcs_snd_state_t;
endpackage

//--- logic/hbcs_flag.sv
/*
 * One sticky status flag: set by a hardware event, cleared by a
 * software write of one. Assumes a synchronous single-cycle event.
 */
`timescale 1ns/1ps
module hbcs_flag (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Set and clear
    input wire logic set_i,
    input wire logic clr_i,
    // State
    output logic flag_o
);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flag_o <= 1'b0;
        end else if (ce_i) begin
            // Set beats clear so a coincident event survives
            if (set_i) begin
                flag_o <= 1'b1;
            end else if (clr_i) begin
                flag_o <= 1'b0;
            end
        end
    end
endmodule // hbcs_flag

//--- logic/hbcs_sender.sv
/*
 * Error message sender toward the hub link. Holds pending requests
 * from device 0 and device 1 and offers one message at a time.
 * Assumes the link accepts a message when ack is high with req.
 */
`timescale 1ns/1ps
module hbcs_sender
    import hbcs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Error events and enables
    input wire logic dev0_err_i,
    input wire logic dev0_en_i,
    input wire logic dev1_err_i,
    input wire logic dev1_en_i,
    // Link handshake
    output logic msg_req_o,
    input wire logic msg_ack_i,
    // Device 0 message went out
    output logic dev0_sent_o
);
    hbcs_snd_state_t state_q;
    logic pend0_q;
    logic pend1_q;
    logic carry0_q;
    logic take;
    logic done;

    assign msg_req_o = (state_q == HBCS_SND_BUSY);
    assign done = msg_req_o && msg_ack_i && ce_i;
    assign take = (state_q == HBCS_SND_IDLE) && (pend0_q || pend1_q) && ce_i;
    assign dev0_sent_o = done && carry0_q;

    // Only enabled errors queue a message; the link output exists only here
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend0_q <= 1'b0;
            pend1_q <= 1'b0;
        end else if (ce_i) begin
            pend0_q <= (dev0_err_i && dev0_en_i) || (pend0_q && !take);
            pend1_q <= (dev1_err_i && dev1_en_i) || (pend1_q && !take);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= HBCS_SND_IDLE;
            carry0_q <= 1'b0;
        end else if (ce_i) begin
            case (state_q)
                HBCS_SND_IDLE: begin
                    if (take) begin
                        state_q <= HBCS_SND_BUSY;
                        carry0_q <= pend0_q;
                    end
                end
                HBCS_SND_BUSY: begin
                    if (msg_ack_i) begin
                        state_q <= HBCS_SND_IDLE;
                    end
                end
                default: state_q <= HBCS_SND_IDLE;
            endcase
        end
    end
endmodule // hbcs_sender

//--- dv/hbcs_hub_peer.sv
/* Hub-link peer model: takes error messages after a set delay.
   Assumes the sender holds its request until it sees the ack. */
`timescale 1ns/1ps
module hbcs_hub_peer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Message handshake
    input wire logic msg_req_i,
    input wire logic [3:0] delay_i,
    output logic msg_ack_o,
    // Messages taken
    output logic [7:0] msg_cnt_o
);
    logic [3:0] wait_q;
    // Ack lasts one cycle, so a held request is counted once
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            msg_ack_o <= 1'b0;
            wait_q <= 4'h0;
            msg_cnt_o <= 8'h00;
        end else if (msg_ack_o) begin
            msg_ack_o <= 1'b0;
            wait_q <= 4'h0;
            msg_cnt_o <= msg_cnt_o + 8'h01;
        end else if (msg_req_i) begin
            if (wait_q >= delay_i) msg_ack_o <= 1'b1;
            else wait_q <= wait_q + 4'h1;
        end
    end
endmodule // hbcs_hub_peer

//--- dv/hbcs_regs_bench.sv
/* Self-checking bench for the bridge command/status registers.
   Assumes the one-cycle dword config port and the peer model. */
`timescale 1ns/1ps
module hbcs_regs_bench;
    logic clk = 1'b0, rstn = 1'b0, req = 1'b0, we = 1'b0, ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [3:0] be = 4'h0, dly = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, rd_q;
    logic ack, d0e = 1'b0, d1e = 1'b0, d1en = 1'b0, mab = 1'b0, tab = 1'b0, spc = 1'b0;
    logic mreq, mack, men;
    logic [7:0] mcnt;
    int error_cnt = 0, cmp_count = 0;
    always #25 clk = ~clk;
    hbcs_regs u_hbcs_regs (.clk_i(clk), .rstn_i(rstn), .ce_i(ce), .cfg_req_i(req), .cfg_we_i(we),
        .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_ack_o(ack),
        .dev0_err_i(d0e), .dev1_err_i(d1e), .dev1_msg_en_i(d1en), .got_master_abort_i(mab),
        .got_target_abort_i(tab), .special_cycle_i(spc), .msg_req_o(mreq), .msg_ack_i(mack),
        .msg_mech_en_o(men));
    hbcs_hub_peer u_hbcs_hub_peer (.clk_i(clk), .rstn_i(rstn), .msg_req_i(mreq), .delay_i(dly),
        .msg_ack_o(mack), .msg_cnt_o(mcnt));
    task check(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task cfg(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        int i;
        req <= 1'b1; we <= w; addr <= a; be <= b; wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        i = 0;
        do begin @(posedge clk); i++; end while (ack !== 1'b1 && i < 4);
        check("ack", 32'h1, {31'h0, ack});
        rd_q = rdata;
    endtask
    task rd_chk(input string n, input logic [31:0] e);
        cfg(1'b0, 8'h04, 4'h0, 32'h0);
        check(n, e, rd_q);
    endtask
    // One-cycle pulse of {dev0, dev1, master abort, target abort, special}
    task evt(input logic [4:0] v);
        {d0e, d1e, mab, tab, spc} <= v;
        @(posedge clk);
        {d0e, d1e, mab, tab, spc} <= 5'h0;
        @(posedge clk);
    endtask
    task wait_msg(input logic [7:0] n);
        int i;
        for (i = 0; i < 40 && mcnt !== n; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        check("msg count", {24'h0, n}, {24'h0, mcnt});
    endtask
    task t_reset_cmd;
        rd_chk("reset image", 32'h0090_0006);
        check("mech off", 32'h0, {31'h0, men});
        cfg(1'b1, 8'h04, 4'hd, 32'hffff_ffff);
        rd_chk("enable needs byte1", 32'h0090_0006);
        cfg(1'b1, 8'h04, 4'hf, 32'hffff_ffff);
        rd_chk("all ones", 32'h0090_0106);
        check("mech on", 32'h1, {31'h0, men});
        cfg(1'b0, 8'h08, 4'hf, 32'h0);
        check("unmapped", 32'h0, rd_q);
        $display("test reset_cmd done");
    endtask
    task t_msg;
        dly <= 4'h5;
        evt(5'h10);
        wait_msg(8'h01);
        rd_chk("sent flag", 32'h4090_0106);
        cfg(1'b1, 8'h04, 4'hf, 32'h0000_0100);
        rd_chk("zero keeps", 32'h4090_0106);
        cfg(1'b1, 8'h04, 4'hf, 32'h4000_0100);
        rd_chk("one clears", 32'h0090_0106);
        cfg(1'b1, 8'h04, 4'hf, 32'h0);
        evt(5'h10);
        repeat (8) @(posedge clk);
        check("disabled drop", 32'h1, {24'h0, mcnt});
        rd_chk("no flag", 32'h0090_0006);
        dly <= 4'h0;
        d1en <= 1'b1;
        evt(5'h08);
        check("mech dev1", 32'h1, {31'h0, men});
        wait_msg(8'h02);
        rd_chk("dev1 no flag", 32'h0090_0006);
        d1en <= 1'b0;
        $display("test msg done");
    endtask
    task t_abort;
        evt(5'h04);
        rd_chk("master abort", 32'h2090_0006);
        evt(5'h02);
        rd_chk("target abort", 32'h3090_0006);
        evt(5'h01);
        rd_chk("special ignored", 32'h3090_0006);
        check("no msg", 32'h2, {24'h0, mcnt});
        cfg(1'b1, 8'h04, 4'hf, 32'h2000_0000);
        rd_chk("clear master", 32'h1090_0006);
        // Enable low must swallow the abort pulse
        ce <= 1'b0;
        evt(5'h04);
        ce <= 1'b1;
        rd_chk("frozen by enable", 32'h1090_0006);
        evt(5'h04);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd_chk("second reset", 32'h0090_0006);
        $display("test abort done");
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset_cmd();
        t_msg();
        t_abort();
        stop_test();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #150000;
        error_cnt++;
        stop_test();
    end
endmodule // hbcs_regs_bench
